// *** switch_ctrl_pkg.sv ***
// Purpose: Shared constants and carrier types for the eight-channel switch control logic.
// Assumes: System clock of 20 MHz; serial link clocked by the master.
// Notes:   Every figure used by more than one place lives here.
package switch_ctrl_pkg;

    localparam int N_OUT = 8;
    localparam int WORD_W = 16;

    // Command word layout: low byte switches outputs, high byte enables open-load current.
    localparam int CMD_ON_LSB = 0;
    localparam int CMD_OL_EN_LSB = 8;
    localparam logic [WORD_W-1:0] CMD_RESET = 16'h0000;

    // Status word: upper byte always reads zero.
    localparam logic [7:0] STATUS_UPPER = 8'h00;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    // Frame length counter: 16 pulses, then every further 8 brings it back to the accept value.
    localparam logic [4:0] FRAME_ACCEPT = 5'h10;
    localparam logic [4:0] FRAME_WRAP = 5'h09;
    localparam logic [4:0] FRAME_FIRST = 5'h01;
    localparam logic [4:0] FRAME_RESET = 5'h00;

    // Open-load fault filter, within the 100 to 300 us window.
    localparam int SYS_CLK_MHZ = 20;
    localparam int FILTER_TIME_US = 200;
    localparam int FILTER_CYCLES = FILTER_TIME_US * SYS_CLK_MHZ;
    localparam logic [11:0] FILTER_LAST = 12'(FILTER_CYCLES - 1);
    localparam logic [11:0] FILTER_RESET = 12'h000;

    typedef struct packed {
        logic [N_OUT-1:0] ol_en;
        logic [N_OUT-1:0] on;
    } cmd_type;

    typedef struct packed {
        logic [N_OUT-1:0] over_temp;
        logic [N_OUT-1:0] over_current;
        logic [N_OUT-1:0] low_vds;
    } fault_in_type;

    typedef struct packed {
        logic         enable;
        logic         logic_ok;
        logic         battery_ok;
        logic         battery_ov;
        fault_in_type fault;
    } pin_type;

endpackage

// *** octal_switch_spi_fault_logic.sv ***
// Purpose: Serial command, output control and fault reporting of an eight-channel switch.
// Assumes: Master holds chip select high and the serial clock still between frames;
//          at least 150 ns from chip select falling to the first serial clock edge.
// Notes:   Serial data is sampled on the rising edge and shifted out on the falling edge.
`timescale 1ns/1ns

module octal_switch_spi_fault_logic (
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    input  wire logic       i_clk_en,
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    input  wire logic       i_enable,
    input  wire logic       i_logic_supply_ok,
    input  wire logic       i_battery_supply_ok,
    input  wire logic       i_battery_overvoltage,
    input  wire logic [7:0] i_thermal_limit,
    input  wire logic [7:0] i_over_current,
    input  wire logic [7:0] i_open_load_threshold,
    output logic            o_miso,
    output logic [7:0]      o_out_on,
    output logic [7:0]      o_ol_current_on
);

    // Link domain state.
    logic [15:0] shreg_r;
    logic [15:0] shreg_nxt;
    logic [4:0]  frame_cnt_r;
    logic [4:0]  frame_cnt_nxt;
    logic        first_r;
    logic        miso_r;
    logic        link_rst_n;

    // System domain state.
    switch_ctrl_pkg::pin_type pins_meta_r;
    switch_ctrl_pkg::pin_type pins_r;
    logic        cs_meta_r;
    logic        cs_sync_r;
    logic        cs_prev_r;
    switch_ctrl_pkg::cmd_type cmd_r;
    switch_ctrl_pkg::cmd_type cmd_nxt;
    logic [7:0]  fault_lat_r;
    logic [7:0]  fault_lat_nxt;
    logic [7:0]  status_snap_r;
    logic [7:0]  status_snap_nxt;
    logic [11:0] filter_cnt_r;
    logic [11:0] filter_cnt_nxt;
    logic        filter_done_r;
    logic        filter_done_nxt;
    logic [7:0]  ol_current_r;
    logic [7:0]  ol_current_nxt;
    logic [7:0]  out_nxt;

    logic        asleep;
    logic        cs_rise;
    logic        cs_fall;
    logic        frame_ok;
    logic [7:0]  fault_now;

    // Chip select high holds the frame-start flag and serial output in reset.
    assign link_rst_n = i_arst_n & ~i_cs_n;

    always_comb begin
        shreg_nxt = {shreg_r[14:0], i_mosi};
        frame_cnt_nxt = frame_cnt_r + 5'h01;
        if (first_r) begin
            // Status loads on the first edge; its top bit is always zero and is already out.
            shreg_nxt = {switch_ctrl_pkg::STATUS_UPPER[6:0], status_snap_r, i_mosi};
            frame_cnt_nxt = switch_ctrl_pkg::FRAME_FIRST;
        end else if (frame_cnt_r == switch_ctrl_pkg::FRAME_ACCEPT) begin
            frame_cnt_nxt = switch_ctrl_pkg::FRAME_WRAP;
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shreg_r <= switch_ctrl_pkg::CMD_RESET;
            frame_cnt_r <= switch_ctrl_pkg::FRAME_RESET;
        end else begin
            shreg_r <= shreg_nxt;
            frame_cnt_r <= frame_cnt_nxt;
        end
    end

    always_ff @(posedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    always_ff @(negedge i_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            miso_r <= 1'b0;
        end else begin
            miso_r <= shreg_r[15];
        end
    end

    assign o_miso = miso_r;

    // Pins and chip select pass two flip-flops before use, except where the thermal limit pins clear the output flops directly.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_meta_r <= '0;
            pins_r <= '0;
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
            cs_prev_r <= 1'b1;
        end else if (i_clk_en) begin
            pins_meta_r <= {i_enable, i_logic_supply_ok, i_battery_supply_ok,
                            i_battery_overvoltage, i_thermal_limit, i_over_current,
                            i_open_load_threshold};
            pins_r <= pins_meta_r;
            cs_meta_r <= i_cs_n;
            cs_sync_r <= cs_meta_r;
            cs_prev_r <= cs_sync_r;
        end
    end

    // Rising edge of a synchronised level; swapping the arguments gives the falling edge.
    function automatic logic edge_of(input logic now_lvl, input logic was_lvl);
        return now_lvl & ~was_lvl;
    endfunction

    // Sleep, a missing logic supply and battery undervoltage all reset the command, filter, fault and output state.
    function automatic logic shut_down(input switch_ctrl_pkg::pin_type p);
        return ~p.enable | ~p.logic_ok | ~p.battery_ok;
    endfunction

    // Events and the present fault picture, shared by the state groups below.
    always_comb begin
        asleep = shut_down(pins_r);
        cs_rise = edge_of(cs_sync_r, cs_prev_r);
        cs_fall = edge_of(cs_prev_r, cs_sync_r);
        frame_ok = (frame_cnt_r == switch_ctrl_pkg::FRAME_ACCEPT);
        // Overtemperature and overcurrent always flag; open-load only when off, enabled, filtered.
        fault_now = pins_r.fault.over_temp | pins_r.fault.over_current
                  | (~cmd_r.on & cmd_r.ol_en & {8{filter_done_r}}
                     & pins_r.fault.low_vds);
    end

    // Command register: loaded only from an accepted frame, cleared by any shutdown.
    always_comb begin
        cmd_nxt = cmd_r;
        if (asleep) begin
            cmd_nxt = switch_ctrl_pkg::CMD_RESET;
        end else if (cs_rise && frame_ok) begin
            // Link words are quiet while chip select is high, so they are read directly.
            cmd_nxt = shreg_r;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_r <= switch_ctrl_pkg::CMD_RESET;
        end else if (i_clk_en) begin
            cmd_r <= cmd_nxt;
        end
    end

    // Fault filter: open-load results count only once it has run out after a frame.
    always_comb begin
        filter_cnt_nxt = filter_cnt_r;
        filter_done_nxt = filter_done_r;
        if (asleep || cs_rise) begin
            filter_cnt_nxt = switch_ctrl_pkg::FILTER_RESET;
            filter_done_nxt = 1'b0;
        end else if (!filter_done_r) begin
            filter_cnt_nxt = filter_cnt_r + 12'h001;
            filter_done_nxt = (filter_cnt_r == switch_ctrl_pkg::FILTER_LAST);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            filter_cnt_r <= switch_ctrl_pkg::FILTER_RESET;
            filter_done_r <= 1'b0;
        end else if (i_clk_en) begin
            filter_cnt_r <= filter_cnt_nxt;
            filter_done_r <= filter_done_nxt;
        end
    end

    // Fault latch: holds every fault seen since the last read of the status word.
    always_comb begin
        fault_lat_nxt = fault_lat_r | fault_now;
        if (asleep) begin
            fault_lat_nxt = switch_ctrl_pkg::FAULT_RESET;
        end else if (cs_fall) begin
            // A fault arriving in the clearing cycle is kept: set wins over clear.
            fault_lat_nxt = fault_now;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault_lat_r <= switch_ctrl_pkg::FAULT_RESET;
        end else if (i_clk_en) begin
            fault_lat_r <= fault_lat_nxt;
        end
    end

    // Status snapshot: follows the latch while idle and freezes while a frame runs,
    // so the link domain reads a word that does not move under it.
    always_comb begin
        status_snap_nxt = status_snap_r;
        if (asleep) begin
            status_snap_nxt = switch_ctrl_pkg::FAULT_RESET;
        end else if (cs_sync_r) begin
            status_snap_nxt = fault_lat_r | fault_now;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_snap_r <= switch_ctrl_pkg::FAULT_RESET;
        end else if (i_clk_en) begin
            status_snap_r <= status_snap_nxt;
        end
    end

    // Output drive and open-load current sources.
    // Retry after overtemperature follows from re-evaluating the command each cycle.
    always_comb begin
        out_nxt = cmd_r.on & ~pins_r.fault.over_temp
                & ~{8{pins_r.battery_ov}} & ~{8{asleep}};
        ol_current_nxt = cmd_r.ol_en & ~{8{asleep}};
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ol_current_r <= switch_ctrl_pkg::FAULT_RESET;
        end else if (i_clk_en) begin
            ol_current_r <= ol_current_nxt;
        end
    end

    assign o_ol_current_on = ol_current_r;

    // Each output flop is cleared at once by its own thermal limit pin, with no clock.
    for (genvar g = 0; g < switch_ctrl_pkg::N_OUT; g++) begin : g_out
        logic out_r;

        always_ff @(posedge i_clk_sys or negedge i_arst_n or posedge i_thermal_limit[g]) begin
            if (!i_arst_n) begin
                out_r <= 1'b0;
            end else if (i_thermal_limit[g]) begin
                out_r <= 1'b0;
            end else if (i_clk_en) begin
                out_r <= out_nxt[g];
            end
        end

        assign o_out_on[g] = out_r;
    end

endmodule

// *** switch_ctrl_assertions.sv ***
// Purpose: Port-level checker for the switch control logic.
// Assumes: Pins are driven shortly after a system clock edge.
// Notes:   Pin synchronisers make the output response three edges late; thermal limit pins clear outputs at once.
`timescale 1ns/1ns
module switch_ctrl_checker (
    input wire logic       i_clk_sys,
    input wire logic       i_arst_n,
    input wire logic       i_cs_n,
    input wire logic       i_enable,
    input wire logic       i_logic_supply_ok,
    input wire logic       i_battery_supply_ok,
    input wire logic       i_battery_overvoltage,
    input wire logic [7:0] i_thermal_limit,
    input wire logic       o_miso,
    input wire logic [7:0] o_out_on,
    input wire logic [7:0] o_ol_current_on
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    thermal_cut_a: assert property ((o_out_on & i_thermal_limit) == 8'h00)
        else $error("hot output on");
    ov_off_a: assert property (i_battery_overvoltage [*4] |-> o_out_on == 8'h00)
        else $error("output on in overvoltage");
    sleep_clear_a: assert property (!i_enable [*4] |-> (o_out_on | o_ol_current_on) == 8'h00)
        else $error("sleep left state");
    logic_loss_a: assert property (!i_logic_supply_ok [*4] |-> o_ol_current_on == 8'h00)
        else $error("current source on");
    battery_low_a: assert property (!i_battery_supply_ok [*4] |-> o_out_on == 8'h00)
        else $error("output on in undervoltage");
    miso_idle_a: assert property (i_cs_n [*2] |-> !o_miso)
        else $error("serial out busy when idle");
    ol_frame_a: assert property ($changed(o_ol_current_on) |-> i_cs_n)
        else $error("current changed in frame");
    cmd_late_a: assert property ($rose(i_cs_n) |-> ##1 $stable(o_ol_current_on))
        else $error("command applied early");
    cover property ($rose(i_cs_n));
    cover property ($rose(i_battery_overvoltage));
    cover property (i_thermal_limit != 8'h00);
endmodule
bind octal_switch_spi_fault_logic switch_ctrl_checker checker_i (.*);

// *** spi_master_model.sv ***
// Purpose: Serial master that runs one frame of up to 32 bits.
// Assumes: Link clock period of 64 ns, idle low.
// Notes:   Data line shows the inverse of its last bit between frames.
`timescale 1ns/1ns
module spi_master_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_mosi,
    input  wire logic i_miso
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        o_cs_n = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            o_mosi = tx[i];
            #32 o_sclk = 1'b1;
            rx = {rx[30:0], i_miso};
            #32 o_sclk = 1'b0;
        end
        #40 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #300;
    endtask
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the switch control logic.
// Assumes: Clock enable held high.
// Notes:   Expected words follow from the command sent.
`timescale 1ns/1ns
module tb_top;
    logic        i_clk_sys = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [2:0]  sup = 3'h7;
    logic        ov = 1'b0;
    logic [7:0]  hot = 8'h00;
    logic [7:0]  oc = 8'h00;
    logic [7:0]  lowv = 8'h00;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic [7:0]  out_on;
    logic [7:0]  ol_on;
    logic [31:0] rx;
    int          fails = 0;
    int          num_checks = 0;
    always #25 i_clk_sys = ~i_clk_sys;
    spi_master_model spi (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
    octal_switch_spi_fault_logic dut (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_en(1'b1),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_enable(sup[0]),
        .i_logic_supply_ok(sup[1]), .i_battery_supply_ok(sup[2]),
        .i_battery_overvoltage(ov), .i_thermal_limit(hot), .i_over_current(oc),
        .i_open_load_threshold(lowv), .o_miso(miso), .o_out_on(out_on),
        .o_ol_current_on(ol_on));
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #5;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic frame(input int n, input logic [31:0] tx);
        spi.xfer(n, tx, rx);
        tick(5);
    endtask
    task automatic test_done;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        fails++;
        test_done();
    end
    initial begin
        tick(6);
        i_arst_n = 1'b1;
        tick(4);
        chk({ol_on, out_on}, 16'h0000);
        frame(16, 32'h3c05);
        chk(rx[15:0], 16'h0000);
        chk({ol_on, out_on}, 16'h3c05);
        frame(12, 32'hfff);
        chk({ol_on, out_on}, 16'h3c05);
        frame(32, 32'ha5c3_0c05);
        chk(rx[31:16], 16'h0000);
        chk(rx[15:0], 16'ha5c3);
        chk({ol_on, out_on}, 16'h0c05);
        lowv = 8'h0e;
        tick(4100);
        lowv = 8'h00;
        tick(4);
        frame(16, 32'h0c05);
        chk(rx[15:0], 16'h0008);
        lowv = 8'h08;
        tick(3000);
        lowv = 8'h00;
        tick(4);
        frame(16, 32'h0c05);
        chk(rx[15:0], 16'h0000);
        hot = 8'h01;
        oc = 8'h10;
        #1;
        chk({8'h00, out_on}, 16'h0004);
        tick(5);
        hot = 8'h00;
        oc = 8'h00;
        tick(5);
        chk({8'h00, out_on}, 16'h0005);
        frame(16, 32'h0c05);
        chk(rx[15:0], 16'h0011);
        ov = 1'b1;
        tick(5);
        chk({ol_on, out_on}, 16'h0c00);
        ov = 1'b0;
        tick(5);
        chk({ol_on, out_on}, 16'h0c05);
        for (int k = 0; k < 3; k++) begin
            frame(16, 32'h0c05);
            sup[k] = 1'b0;
            tick(5);
            chk({ol_on, out_on}, 16'h0000);
            sup[k] = 1'b1;
            tick(5);
            chk({ol_on, out_on}, 16'h0000);
        end
        test_done();
    end
endmodule
